// File: inc/watch_pkg.sv
/*
  Constants for the four data watchpoint pairs: register offsets, field
  positions, writable masks, reset values and field encodings.
  Assumes a 12-bit byte offset inside the debug register window.
*/
`default_nettype none
package watch_pkg;
  localparam int NUM_PAIRS = 4;
  localparam int ADDR_W = 12;
  localparam int LINK_W = 16;

  // Byte offsets of the value and control registers, index 0 last
  localparam logic [3:0][11:0] VALUE_OFF = {12'h18c, 12'h188, 12'h184, 12'h180};
  localparam logic [3:0][11:0] CTRL_OFF = {12'h1dc, 12'h1c8, 12'h1c4, 12'h1c0};

  // Writable bits; all others read as zero
  localparam logic [31:0] VALUE_RW_MASK = 32'hfffffffc;
  localparam logic [31:0] CTRL_RW_MASK = 32'h1f1fc1ff;
  localparam logic [31:0] VALUE_RST = 32'h00000000;
  localparam logic [31:0] CTRL_RST = 32'h00000000;

  // Control field positions
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_PRIV_LSB = 1;
  localparam int CTL_TYPE_LSB = 3;
  localparam int CTL_BYTE_LSB = 5;
  localparam int CTL_SEC_LSB = 14;
  localparam int CTL_LINK_IDX_LSB = 16;
  localparam int CTL_LINK_EN_BIT = 20;
  localparam int CTL_AMASK_LSB = 24;

  // Security qualifier encodings
  localparam logic [1:0] SEC_BOTH = 2'h0;
  localparam logic [1:0] SEC_NONSEC = 2'h1;
  localparam logic [1:0] SEC_SECURE = 2'h2;
  // Access type encodings
  localparam logic [1:0] TYPE_LOAD = 2'h1;
  localparam logic [1:0] TYPE_STORE = 2'h2;
  localparam logic [1:0] TYPE_EITHER = 2'h3;
  // Privilege encodings
  localparam logic [1:0] PRIV_PRIV = 2'h1;
  localparam logic [1:0] PRIV_USER = 2'h2;
  localparam logic [1:0] PRIV_ANY = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : watch_pkg
`default_nettype wire

// File: inc/watch_acc_if.sv
/*
  Interface carrying one processor data access and the context match
  vector from the breakpoint logic to each pair comparator.
  Assumes all signals are on the processor clock.
*/
`default_nettype none
interface watch_acc_if;
  logic valid;
  logic [31:0] addr;
  logic [3:0] bytes;
  logic load;
  logic store;
  logic priv;
  logic nonsecure;
  logic [15:0] ctx_match;
  modport src(output valid, addr, bytes, load, store, priv, nonsecure, ctx_match);
  modport cmp(input valid, addr, bytes, load, store, priv, nonsecure, ctx_match);
endinterface : watch_acc_if
`default_nettype wire

// File: verilog/watch_compare.sv
/*
  Combinational comparator for one watch pair against the current access.
  Assumes the value and control words are already masked to writable bits.
*/
`default_nettype none
module watch_compare (
  watch_acc_if.cmp acc,
  input wire logic [31:0] i_value,
  input wire logic [31:0] i_ctrl,
  output logic o_hit
);
  logic [4:0] amask;
  logic [31:0] cmp_mask;
  logic [1:0] sec;
  logic [1:0] ltype;
  logic [1:0] psel;
  logic [3:0] lanes;
  logic [3:0] link_idx;
  logic addr_ok, byte_ok, type_ok, priv_ok, sec_ok, link_ok;

  assign amask = i_ctrl[watch_pkg::CTL_AMASK_LSB +: 5];
  assign sec = i_ctrl[watch_pkg::CTL_SEC_LSB +: 2];
  assign ltype = i_ctrl[watch_pkg::CTL_TYPE_LSB +: 2];
  assign psel = i_ctrl[watch_pkg::CTL_PRIV_LSB +: 2];
  assign lanes = i_ctrl[watch_pkg::CTL_BYTE_LSB +: 4];
  assign link_idx = i_ctrl[watch_pkg::CTL_LINK_IDX_LSB +: 4];

  // Word compare, low bits dropped by the mask count
  assign cmp_mask = (32'hffffffff << amask) & watch_pkg::VALUE_RW_MASK;
  assign addr_ok = ((acc.addr ^ i_value) & cmp_mask) == 32'h00000000;
  // Lanes only mean something for an unmasked word
  assign byte_ok = (amask != 5'h00) || ((acc.bytes & lanes) != 4'h0);

  // Qualifiers; reserved codes never match
  always_comb begin
    unique case (ltype)
      watch_pkg::TYPE_LOAD: type_ok = acc.load;
      watch_pkg::TYPE_STORE: type_ok = acc.store;
      watch_pkg::TYPE_EITHER: type_ok = acc.load | acc.store;
      default: type_ok = 1'b0;
    endcase
    unique case (psel)
      watch_pkg::PRIV_PRIV: priv_ok = acc.priv;
      watch_pkg::PRIV_USER: priv_ok = ~acc.priv;
      watch_pkg::PRIV_ANY: priv_ok = 1'b1;
      default: priv_ok = 1'b0;
    endcase
    unique case (sec)
      watch_pkg::SEC_BOTH: sec_ok = 1'b1;
      watch_pkg::SEC_NONSEC: sec_ok = acc.nonsecure;
      watch_pkg::SEC_SECURE: sec_ok = ~acc.nonsecure;
      default: sec_ok = 1'b0;
    endcase
  end

  // Linked pair needs the chosen context match in the same cycle
  assign link_ok = ~i_ctrl[watch_pkg::CTL_LINK_EN_BIT] | acc.ctx_match[link_idx];

  assign o_hit = acc.valid & i_ctrl[watch_pkg::CTL_EN_BIT] & addr_ok & byte_ok
               & type_ok & priv_ok & sec_ok & link_ok;
endmodule : watch_compare
`default_nettype wire

// File: verilog/data_watchpoint_pairs.sv
/*
  Four data watchpoint pairs behind an AXI4-Lite slave, compared against
  the processor load/store access path; raises a registered debug event.
  Assumes access and context match inputs come from logic on i_clk.
*/
// Functional notes
// - Four pairs, value and control matched by index
// - Value bits 31:2 hold the watched word
// - Reserved bits read zero, writes ignored
// - Match on address, or address plus context
// - Linked event needs both matches together
// - Control bit 20 enables linking
// - Control bits 19:16 select linked break pair
// - Bits 15:14 qualify by security state
// - Bits 8:5 select watched byte lanes
// - Access type b00 is reserved, no match
// - Type b01 loads, b10 stores, b11 both
// - Bits 2:1 qualify by access privilege
// - Bit 0 enables pair, resets to zero
`default_nettype none
module data_watchpoint_pairs #(
  parameter int NUM_PAIRS = watch_pkg::NUM_PAIRS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_acc_valid,
  input wire logic [31:0] i_acc_addr,
  input wire logic [3:0] i_acc_bytes,
  input wire logic i_acc_load,
  input wire logic i_acc_store,
  input wire logic i_acc_priv,
  input wire logic i_acc_nonsecure,
  input wire logic [15:0] i_ctx_match,
  output logic o_watch_event,
  output logic [NUM_PAIRS-1:0] o_watch_hit
);
  // Decoded register select: hit, control flag, pair index
  typedef struct packed {
    logic hit;
    logic is_ctrl;
    logic [1:0] idx;
  } reg_sel_t;

  logic [NUM_PAIRS-1:0][31:0] value_q;
  logic [NUM_PAIRS-1:0][31:0] ctrl_q;
  logic [NUM_PAIRS-1:0] hit;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [11:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  reg_sel_t wsel, rsel;
  logic event_q;
  logic [NUM_PAIRS-1:0] hit_q;

  // Shared by write and read paths; low two address bits ignored
  function automatic reg_sel_t decode(input logic [11:0] a);
    reg_sel_t s;
    s = '0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (a[11:2] == watch_pkg::VALUE_OFF[i][11:2]) begin
        s.hit = 1'b1;
        s.is_ctrl = 1'b0;
        s.idx = 2'(i);
      end
      if (a[11:2] == watch_pkg::CTRL_OFF[i][11:2]) begin
        s.hit = 1'b1;
        s.is_ctrl = 1'b1;
        s.idx = 2'(i);
      end
    end
    return s;
  endfunction : decode

  // Byte-lane merge, then drop bits that must stay zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] keep);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m & keep;
  endfunction : merge

  assign wsel = decode(waddr_q);
  assign rsel = decode(i_araddr);
  // Both halves held and no response pending
  assign do_write = ~awready_q & ~wready_q & ~bvalid_q;

  // Write address channel; held until the response is taken
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      awready_q <= 1'b1;
      waddr_q <= 12'h000;
    end else if (awready_q && i_awvalid) begin
      awready_q <= 1'b0;
      waddr_q <= i_awaddr;
    end else if (bvalid_q && i_bready) begin
      awready_q <= 1'b1;
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wready_q <= 1'b1;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (wready_q && i_wvalid) begin
      wready_q <= 1'b0;
      wdata_q <= i_wdata;
      wstrb_q <= i_wstrb;
    end else if (bvalid_q && i_bready) begin
      wready_q <= 1'b1;
    end
  end

  // Write response; unmapped offsets answer SLVERR and change nothing
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q <= watch_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wsel.hit ? watch_pkg::RESP_OKAY : watch_pkg::RESP_SLVERR;
    end else if (bvalid_q && i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // One process per pair for its value and control words
  for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        value_q[g] <= watch_pkg::VALUE_RST;
        ctrl_q[g] <= watch_pkg::CTRL_RST; // Pair disabled out of reset
      end else if (do_write && wsel.hit && wsel.idx == 2'(g)) begin
        if (wsel.is_ctrl) begin
          ctrl_q[g] <= merge(ctrl_q[g], wdata_q, wstrb_q, watch_pkg::CTRL_RW_MASK);
        end else begin
          value_q[g] <= merge(value_q[g], wdata_q, wstrb_q, watch_pkg::VALUE_RW_MASK);
        end
      end
    end
  end

  // Read channel; data captured at the address handshake
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= watch_pkg::RESP_OKAY;
    end else if (arready_q && i_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rsel.hit ? watch_pkg::RESP_OKAY : watch_pkg::RESP_SLVERR;
      if (!rsel.hit) begin
        rdata_q <= 32'h00000000;
      end else if (rsel.is_ctrl) begin
        rdata_q <= ctrl_q[rsel.idx]; // Stored masked, so reserved bits read zero
      end else begin
        rdata_q <= value_q[rsel.idx];
      end
    end else if (rvalid_q && i_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Access path handed to the comparators; same clock, so no synchroniser
  watch_acc_if acc ();
  assign acc.valid = i_acc_valid;
  assign acc.addr = i_acc_addr;
  assign acc.bytes = i_acc_bytes;
  assign acc.load = i_acc_load;
  assign acc.store = i_acc_store;
  assign acc.priv = i_acc_priv;
  assign acc.nonsecure = i_acc_nonsecure;
  assign acc.ctx_match = i_ctx_match;

  // Comparator per pair
  for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_cmp
    watch_compare u_cmp (
      .acc(acc),
      .i_value(value_q[g]),
      .i_ctrl(ctrl_q[g]),
      .o_hit(hit[g])
    );
  end

  // Registered event: one cycle after the access, trading latency for timing
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      event_q <= 1'b0;
      hit_q <= '0;
    end else begin
      event_q <= |hit;
      hit_q <= hit;
    end
  end

  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_watch_event = event_q;
  assign o_watch_hit = hit_q;

  // Checks on the design's own outputs
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_write_resp: assert property (
    (!awready_q && !wready_q && !bvalid_q) |=> bvalid_q)
    else $error("write response missing one cycle after both halves held");

  chk_resp_holds: assert property (
    (o_rvalid && !i_rready) |=> (o_rvalid && $stable(o_rdata)))
    else $error("read data dropped before handshake");

  chk_read_raz: assert property (
    (arready_q && i_arvalid && rsel.hit && !rsel.is_ctrl) |=> (o_rdata[1:0] == 2'h0))
    else $error("value register low bits not zero");

  chk_ctrl_raz: assert property (
    (arready_q && i_arvalid && rsel.hit && rsel.is_ctrl)
      |=> ((o_rdata & ~watch_pkg::CTRL_RW_MASK) == 32'h00000000))
    else $error("reserved control bits read nonzero");

  chk_no_access: assert property (
    !i_acc_valid |=> !o_watch_event)
    else $error("event without an access");

  chk_enable_needed: assert property (
    o_watch_hit[0] |-> $past(ctrl_q[0][watch_pkg::CTL_EN_BIT]))
    else $error("disabled pair reported a hit");

  chk_link_context: assert property (
    (i_acc_valid && ctrl_q[0][watch_pkg::CTL_LINK_EN_BIT]
      && !i_ctx_match[ctrl_q[0][watch_pkg::CTL_LINK_IDX_LSB +: 4]]) |=> !o_watch_hit[0])
    else $error("linked pair hit without context match");

  // Pair zero carries the table cases, so the qualifier checks watch it
  chk_sec_reserved: assert property (
    (ctrl_q[0][watch_pkg::CTL_SEC_LSB +: 2] == 2'h3) |=> !o_watch_hit[0])
    else $error("reserved security code matched");

  chk_type_reserved: assert property (
    (ctrl_q[0][watch_pkg::CTL_TYPE_LSB +: 2] == 2'h0) |=> !o_watch_hit[0])
    else $error("reserved access type matched");

  chk_priv_user: assert property (
    (i_acc_priv && ctrl_q[0][watch_pkg::CTL_PRIV_LSB +: 2] == watch_pkg::PRIV_USER)
      |=> !o_watch_hit[0])
    else $error("user-only pair hit on privileged access");

  chk_priv_match: assert property (
    (i_acc_valid && ctrl_q[0][watch_pkg::CTL_PRIV_LSB +: 2] == watch_pkg::PRIV_PRIV
      && !i_acc_priv) |=> !o_watch_hit[0])
    else $error("privileged-only pair hit on a user access");

  chk_word_miss: assert property (
    (i_acc_valid && ctrl_q[0][watch_pkg::CTL_AMASK_LSB +: 5] == 5'h00
      && i_acc_addr[31:2] != value_q[0][31:2]) |=> !o_watch_hit[0])
    else $error("pair hit on a different word");

  chk_mask_range: assert property (
    (i_acc_valid && ctrl_q[0][watch_pkg::CTL_AMASK_LSB +: 5] == 5'h04
      && i_acc_addr[31:4] != value_q[0][31:4]) |=> !o_watch_hit[0])
    else $error("masked pair hit outside its range");

  chk_lane_miss: assert property (
    (i_acc_valid && ctrl_q[0][watch_pkg::CTL_AMASK_LSB +: 5] == 5'h00
      && (i_acc_bytes & ctrl_q[0][watch_pkg::CTL_BYTE_LSB +: 4]) == 4'h0) |=> !o_watch_hit[0])
    else $error("pair hit on an unselected byte lane");

  chk_sec_match: assert property (
    (i_acc_valid && ctrl_q[0][watch_pkg::CTL_SEC_LSB +: 2] == watch_pkg::SEC_NONSEC
      && !i_acc_nonsecure) |=> !o_watch_hit[0])
    else $error("non-secure-only pair hit on a secure access");

  chk_type_match: assert property (
    (i_acc_valid && ctrl_q[0][watch_pkg::CTL_TYPE_LSB +: 2] == watch_pkg::TYPE_LOAD
      && !i_acc_load) |=> !o_watch_hit[0])
    else $error("load-only pair hit without a load");

  // Positive checks, so a comparator stuck at zero is caught too
  chk_full_match: assert property (
    (i_acc_valid && ctrl_q[0] == 32'h000001ff && i_acc_addr[31:2] == value_q[0][31:2]
      && i_acc_bytes != 4'h0 && (i_acc_load || i_acc_store)) |=> o_watch_hit[0])
    else $error("fully matching access gave no hit");

  chk_link_index: assert property (
    (i_acc_valid && ctrl_q[0] == 32'h001501ff && i_acc_addr[31:2] == value_q[0][31:2]
      && i_acc_bytes != 4'h0 && (i_acc_load || i_acc_store) && i_ctx_match[5])
      |=> o_watch_hit[0])
    else $error("linked pair missed its selected context match");

  chk_event_any: assert property (
    o_watch_event == (|o_watch_hit))
    else $error("event and per-pair hits disagree");

  chk_ready_hold: assert property (
    o_bvalid |-> (!o_awready && !o_wready))
    else $error("write channel ready while a response is pending");

  chk_read_refused: assert property (
    o_rvalid |-> !o_arready)
    else $error("read address ready while read data is pending");

  chk_unmapped_write: assert property (
    (do_write && !wsel.hit) |=> (o_bresp == watch_pkg::RESP_SLVERR))
    else $error("unmapped write answered okay");

  cov_write: cover property (o_bvalid && i_bready && o_bresp == watch_pkg::RESP_OKAY);
  cov_read: cover property (o_rvalid && i_rready);
  cov_event: cover property (o_watch_event);
  cov_linked: cover property (o_watch_hit[0] && $past(ctrl_q[0][watch_pkg::CTL_LINK_EN_BIT]));
  cov_masked: cover property (o_watch_hit[0]
    && $past(ctrl_q[0][watch_pkg::CTL_AMASK_LSB +: 5]) != 5'h00);
endmodule : data_watchpoint_pairs
`default_nettype wire

// File: verification/acc_source.sv
/*
  Processor data access source facing the watchpoint pairs.
  Assumes the bench calls its tasks one at a time from a process on i_clk.
*/
`default_nettype none
module acc_source (
  input wire logic i_clk,
  output logic o_valid,
  output logic [31:0] o_addr,
  output logic [3:0] o_bytes,
  output logic o_load,
  output logic o_store,
  output logic o_priv,
  output logic o_nonsecure,
  output logic [15:0] o_ctx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero so no input floats
  initial begin
    {o_valid, o_addr, o_bytes, o_load, o_store, o_priv, o_nonsecure, o_ctx} = '0;
  end
  // One access in the cycle after the next edge; a swap drives load and store
  task automatic send(input logic [31:0] a, input logic [3:0] b, input logic ld,
      input logic st, input logic pr, input logic ns, input logic [15:0] cx);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_addr <= a;
    o_bytes <= b;
    o_load <= ld;
    o_store <= st;
    o_priv <= pr;
    o_nonsecure <= ns;
    o_ctx <= cx; // Context hits only from context-capable break pairs
  endtask : send
  // Address, lanes and context show a changed pattern, never the last access
  task automatic idle();
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_addr <= ~o_addr;
    o_bytes <= ~o_bytes;
    o_ctx <= ~o_ctx;
  endtask : idle
endmodule : acc_source
`default_nettype wire

// File: verification/data_watchpoint_pairs_tb.sv
/*
  Self-checking bench for the four watchpoint pairs: register access over
  AXI4-Lite, then a table of access cases, then reset and edge cases.
  Assumes the access source model drives the processor side.
*/
`default_nettype none
module data_watchpoint_pairs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] ctrl; logic [31:0] addr; logic [3:0] bytes;
    logic ld; logic st; logic pr; logic ns; logic [15:0] ctx; logic hit;
  } row_t;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0;
  logic [11:0] i_awaddr = 12'h0, i_araddr = 12'h0;
  logic i_rready = 1'b0;
  logic [3:0] i_wstrb = 4'hf;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_watch_event;
  logic [1:0] o_bresp, o_rresp;
  logic [3:0] o_watch_hit, acc_bytes;
  logic acc_valid, acc_load, acc_store, acc_priv, acc_ns;
  logic [31:0] acc_addr;
  logic [15:0] ctx;
  int fail_count = 0, n_compared = 0;
  // Base access: word 0x1000, lane 0, load, privileged, non-secure
  row_t rows [23] = '{
    '{32'h1ff, 32'h1000, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b1},
    '{32'h1ff, 32'h1004, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h1fe, 32'h1000, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h1ef, 32'h1000, 4'hf, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h1ef, 32'h1000, 4'hf, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0, 1'b1},
    '{32'h1f7, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h1f7, 32'h1000, 4'hf, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0, 1'b1},
    '{32'h1e7, 32'h1000, 4'hf, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h1fb, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0, 1'b0},
    '{32'h1fb, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b1},
    '{32'h1fd, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h1f9, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h41ff, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0, 1'b0},
    '{32'h81ff, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h81ff, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0, 1'b1},
    '{32'hc1ff, 32'h1000, 4'hf, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0, 1'b0},
    '{32'h5f, 32'h1000, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h5f, 32'h1000, 4'h2, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b1},
    '{32'h040001ff, 32'h100c, 4'h8, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b1},
    '{32'h040001ff, 32'h1010, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h001501ff, 32'h1000, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0, 1'b0},
    '{32'h001501ff, 32'h1000, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h20, 1'b1},
    '{32'h001501ff, 32'h1000, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h10, 1'b0}
  };
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  acc_source src (.i_clk(i_clk), .o_valid(acc_valid), .o_addr(acc_addr),
    .o_bytes(acc_bytes), .o_load(acc_load), .o_store(acc_store), .o_priv(acc_priv),
    .o_nonsecure(acc_ns), .o_ctx(ctx));
  data_watchpoint_pairs dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(1'b1),
    .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .i_acc_valid(acc_valid), .i_acc_addr(acc_addr), .i_acc_bytes(acc_bytes),
    .i_acc_load(acc_load), .i_acc_store(acc_store), .i_acc_priv(acc_priv),
    .i_acc_nonsecure(acc_ns), .i_ctx_match(ctx), .o_watch_event(o_watch_event),
    .o_watch_hit(o_watch_hit));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bready is tied high, so a write ends on bvalid; only the watchdog ends a hang
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    chk({30'h0, o_bresp}, {30'h0, er});
  endtask : axi_write
  // Rready rises only once rvalid is seen, so the held-data path is used too
  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid && !i_rready) i_rready <= 1'b1;
    end while (!(o_rvalid && i_rready));
    i_rready <= 1'b0;
    chk(o_rdata, ed);
    chk({30'h0, o_rresp}, {30'h0, er});
  endtask : axi_read
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    // Every register starts at zero, pairs disabled
    for (int i = 0; i < 4; i++) begin
      axi_read(watch_pkg::VALUE_OFF[i], 32'h0, watch_pkg::RESP_OKAY);
      axi_read(watch_pkg::CTRL_OFF[i], 32'h0, watch_pkg::RESP_OKAY);
    end
    axi_write(12'h180, 32'h1000, watch_pkg::RESP_OKAY);
    foreach (rows[i]) begin
      axi_write(12'h1c0, rows[i].ctrl, watch_pkg::RESP_OKAY);
      src.send(rows[i].addr, rows[i].bytes, rows[i].ld, rows[i].st, rows[i].pr, rows[i].ns,
        rows[i].ctx);
      src.idle();
      #1;
      chk({28'h0, o_watch_hit}, {31'h0, rows[i].hit});
      chk({31'h0, o_watch_event}, {31'h0, rows[i].hit});
      @(posedge i_clk);
      #1;
      chk({31'h0, o_watch_event}, 32'h0);
    end
    // Reserved bits drop on write and read back as zero
    axi_write(12'h184, 32'hffffffff, watch_pkg::RESP_OKAY);
    axi_read(12'h184, 32'hfffffffc, watch_pkg::RESP_OKAY);
    // Only the strobed byte lane changes
    i_wstrb <= 4'h2;
    axi_write(12'h184, 32'h0, watch_pkg::RESP_OKAY);
    i_wstrb <= 4'hf;
    axi_read(12'h184, 32'hffff00fc, watch_pkg::RESP_OKAY);
    axi_write(12'h1c4, 32'hffffffff, watch_pkg::RESP_OKAY);
    axi_read(12'h1c4, 32'h1f1fc1ff, watch_pkg::RESP_OKAY);
    // The gap between pair two and pair three is not a register
    axi_write(12'h1cc, 32'h1ff, watch_pkg::RESP_SLVERR);
    axi_read(12'h1cc, 32'h0, watch_pkg::RESP_SLVERR);
    // Pair three, back to back with pair zero
    axi_write(12'h1c4, 32'h0, watch_pkg::RESP_OKAY);
    axi_write(12'h18c, 32'h2000, watch_pkg::RESP_OKAY);
    axi_write(12'h1dc, 32'h1ff, watch_pkg::RESP_OKAY);
    axi_write(12'h1c0, 32'h1ff, watch_pkg::RESP_OKAY);
    src.send(32'h2000, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0);
    src.send(32'h1000, 4'h1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0);
    #1;
    chk({28'h0, o_watch_hit}, 32'h8);
    src.idle();
    #1;
    chk({28'h0, o_watch_hit}, 32'h1);
    // Reset in mid-run clears every pair and frees the bus
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    @(posedge i_clk);
    chk({29'h0, o_awready, o_wready, o_arready}, 32'h7);
    i_rst_b <= 1'b1;
    src.send(32'h2000, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0);
    src.idle();
    #1;
    chk({28'h0, o_watch_hit}, 32'h0);
    axi_read(12'h1dc, 32'h0, watch_pkg::RESP_OKAY);
    report_and_stop();
  end
endmodule : data_watchpoint_pairs_tb
`default_nettype wire
